// *** dv/hspsc_ctrl_tb.sv ***
// Self-checking bench for the high-speed power-save controller
// Assumes the 20 MHz clock; bench drives all ports, no partner model
`timescale 1ns/10ps
module hspsc_ctrl_tb;
  logic ref_clk;
  logic rst_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic wake_event;
  logic fast_osc_amp_ok;
  logic core_clk_en;
  logic fast_osc_run;
  logic slow_osc_enable;
  logic idle_clock_source_sel;
  logic idle_irq;
  logic self_reset_req;
  logic fetch_restart;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  int t1;
  logic [2:0] s;

  hspsc_ctrl #(.TIMER_WIDTH(16)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_event(wake_event), .fast_osc_amp_ok(fast_osc_amp_ok), .core_clk_en(core_clk_en),
    .fast_osc_run(fast_osc_run), .slow_osc_enable(slow_osc_enable),
    .idle_clock_source_sel(idle_clock_source_sel), .idle_irq(idle_irq),
    .self_reset_req(self_reset_req), .fetch_restart(fetch_restart));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic a, input logic e, input string m);
    comparisons++;
    if (a !== e)
    begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic chk8(input logic [7:0] a, input logic [7:0] e);
    comparisons++;
    if (a !== e)
    begin
      num_errors++;
      $display("BAD %0t read %h expected %h", $time, a, e);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi, input string m);
    comparisons++;
    if (v < lo || v > hi)
    begin
      num_errors++;
      $display("BAD %0t %s %0d", $time, m, v);
    end
  endtask

  // Read data stands only in the cycle after the strobe, so look exactly there
  always @(posedge ref_clk)
  begin
    if (rd_pend)
      chk8(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end

  // An edge passes after each strobe so no signal is assigned twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Registered outputs settle one edge after the register; let that edge pass
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_core(input logic v, input int lim, output int k);
    k = 0;
    while (core_clk_en !== v && k < lim)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk(core_clk_en, v, "core clock wait");
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk(fetch_restart, 1'b1, "restart in reset");
    chk(core_clk_en, 1'b1, "core on in reset");
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(fetch_restart, 1'b0, "restart after reset");
  endtask

  // One idle window: exits come one tap toggle (one window) apart, so the timer ran through idle
  task automatic idle_run(input logic [2:0] sel);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h40 | {5'h00, sel});
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h40);
    wait_core(1'b0, 12, n);
    chk(fast_osc_run, 1'b1, "osc in idle");
    wait_core(1'b1, (2048 << sel) * 5 + 20, n);
    t1 = $time / 50;
    chk(idle_irq, 1'b1, "idle irq");
    rd(4'h2, 8'h03);
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h40);
    wait_core(1'b0, 12, n);
    wait_core(1'b1, (2048 << sel) * 5 + 20, n);
    chk_rng($time / 50 - t1, (2048 << sel) * 5, (2048 << sel) * 5, "idle window");
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is at most about 66k cycles; idle waits dominate
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    test_done();
  end

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    wake_event = 1'b0;
    fast_osc_amp_ok = 1'b1;
    void'($urandom(92));
    @(posedge ref_clk);
    do_reset();
    rd(4'h1, 8'h40);
    chk(idle_clock_source_sel, 1'b0, "fast source");
    s = 3'($urandom_range(4, 0));
    wr(4'h1, 8'hc0 | {5'h00, s});
    chk(slow_osc_enable, 1'b1, "slow osc on");
    wr(4'h1, 8'he0 | {5'h00, s});
    chk(idle_clock_source_sel, 1'b1, "slow source");
    wr(4'h1, 8'hc0 | {5'h00, s});
    wr(4'h1, 8'h40 | {5'h00, s});
    chk(slow_osc_enable, 1'b0, "slow osc off");
    chk(self_reset_req, 1'b0, "legal sequence");
    rd(4'h1, 8'h40 | {5'h00, s});
    wr(4'h1, 8'h4c);
    rd(4'h1, 8'h44);
    wr(4'h5, 8'($urandom));
    rd(4'h5, 8'h00);
    rd(4'h0, 8'h00);
    wr(4'h1, 8'h54);
    chk(self_reset_req, 1'b1, "illegal nibble");
    do_reset();
    rd(4'h1, 8'h40);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h80);
    repeat (10) @(posedge ref_clk);
    chk(core_clk_en, 1'b1, "halt disabled");
    rd(4'h3, 8'h00);
    wr(4'h4, 8'h02);
    fast_osc_amp_ok <= 1'b0;
    // Two quiet cycles follow the halt write, as the no-ops would
    wr(4'h0, 8'h80);
    wait_core(1'b0, 12, n);
    @(posedge ref_clk);
    chk(fast_osc_run, 1'b0, "osc stopped");
    rd(4'h3, 8'h01);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    repeat ($urandom_range(400, 100)) @(posedge ref_clk);
    chk(core_clk_en, 1'b0, "no count on weak osc");
    fast_osc_amp_ok <= 1'b1;
    wait_core(1'b1, 2000, n);
    chk_rng(n, 1276, 1292, "startup delay");
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h80);
    wait_core(1'b0, 12, n);
    do_reset();
    rd(4'h1, 8'h40);
    idle_run(3'h0);
    idle_run(3'h1);
    wr(4'h0, 8'h40);
    wait_core(1'b0, 12, n);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    wait_core(1'b1, 6, n);
    repeat (4) @(posedge ref_clk);
    test_done();
  end
endmodule // hspsc_ctrl_tb

// *** hdl/hspsc_ctrl.sv ***
// High-speed power-save controller: HALT, wake start-up count, IDLE and window timer
// Assumes a synchronous register port, synchronous wake and amplitude inputs
`timescale 1ns/10ps
// Function
// - Reset always returns to high-speed mode with fast clocks everywhere
// - Writing halt bit one enters HALT next instruction cycle
// - HALT stops the core clock and the fast oscillator pin
// - HALT ends on reset pin low or a wake-up event
// - Reset exit reinitialises registers and restarts fetch at zero
// - Wake from HALT always applies start-up delay, ignoring clock-delay option
// - Start-up loads 256 and counts instruction cycles down to zero
// - Start-up count advances only while oscillator amplitude is good
// - HALT-disable option makes halt bit writes ignored
// - IDLE stops execution, oscillator and idle timer keep running
// - Writing idle bit one with halt bit zero enters IDLE
// - Window is 2k, 4k, 8k, 16k or 32k instruction cycles
// - Idle timer runs except in HALT and wake-up, invisible to software, cleared by reset
// - Each selected tap toggle sets pending, interrupts if enabled, ends IDLE
// - Enabled interrupt is serviced after the entry instruction completes
// - IDLE ends on reset or wake; reset selects the 2k tap
// - Interrupt enable bit lives in the interrupt control register
// - Mode-control top bit switches the slow oscillator
// - Clock source bit selects fast or slow idle timer clock
// - Reset loads mode-control with only the fast enable set
// - Illegal upper mode-control nibble forces a self reset
module hspsc_ctrl #(
  parameter int TIMER_WIDTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Wake and oscillator
  input wire logic wake_event,
  input wire logic fast_osc_amp_ok,
  // Core controls
  output logic core_clk_en,
  output logic fast_osc_run,
  output logic slow_osc_enable,
  output logic idle_clock_source_sel,
  output logic idle_irq,
  output logic self_reset_req,
  output logic fetch_restart
);
  hspsc_pkg::hspsc_state_e state_q;
  logic [7:0] mode_control_reg_q;
  logic idle_int_enable_q;
  logic idle_pending_flag_q;
  logic [1:0] option_q;
  logic [2:0] div_q;
  logic tick;
  logic [TIMER_WIDTH-1:0] timer_q;
  logic [8:0] start_cnt_q;
  logic tap_toggle;
  logic halt_req_q;
  logic wr_portg;
  logic [3:0] nib;
  logic nib_ok;

  assign wr_portg = reg_wr && reg_addr == hspsc_pkg::ADDR_PORTG;
  assign nib = mode_control_reg_q[7:4];
  assign nib_ok = nib == hspsc_pkg::NIB_HIGH || nib == hspsc_pkg::NIB_H2D || nib == hspsc_pkg::NIB_DUAL
    || nib == hspsc_pkg::NIB_D2L || nib == hspsc_pkg::NIB_LOW;

  // Instruction tick: fast clock divided by five, held while halted
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 3'h0;
    else if (state_q == hspsc_pkg::HSPSC_HALT)
      div_q <= 3'h0;
    else if (div_q == hspsc_pkg::DIV_LAST)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end
  assign tick = div_q == hspsc_pkg::DIV_LAST;

  // Window timer, stopped in HALT and WAKE; cleared only to give simulation a known value
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_q <= '0;
    else if (tick && state_q != hspsc_pkg::HSPSC_HALT && state_q != hspsc_pkg::HSPSC_WAKE)
      timer_q <= timer_q - 1'b1;
  end

  hspsc_tap_sel #(
    .TW(TIMER_WIDTH)
  ) u_tap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .timer(timer_q),
    .sel(mode_control_reg_q[2:0]),
    .toggle_q(tap_toggle)
  );

  // Mode-control register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_control_reg_q <= hspsc_pkg::MODE_RESET;
    else if (reg_wr && reg_addr == hspsc_pkg::ADDR_MODE)
      mode_control_reg_q <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
  end

  // Interrupt control: enable written, pending set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      idle_int_enable_q <= 1'b0;
    else if (reg_wr && reg_addr == hspsc_pkg::ADDR_ICTRL)
      idle_int_enable_q <= reg_wdata[hspsc_pkg::IC_ENABLE_BIT];
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      idle_pending_flag_q <= 1'b0;
    else if (tap_toggle)
      idle_pending_flag_q <= 1'b1;
    else if (reg_wr && reg_addr == hspsc_pkg::ADDR_ICTRL)
      idle_pending_flag_q <= reg_wdata[hspsc_pkg::IC_PEND_BIT];
  end

  // Option bits: halt disable and clock delay
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      option_q <= 2'h0;
    else if (reg_wr && reg_addr == hspsc_pkg::ADDR_OPTION)
      option_q <= reg_wdata[1:0];
  end

  // Halt request waits for the next instruction boundary
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      halt_req_q <= 1'b0;
    else if (state_q != hspsc_pkg::HSPSC_RUN)
      halt_req_q <= 1'b0;
    else if (wr_portg && reg_wdata[hspsc_pkg::PG_HALT_BIT] && !option_q[hspsc_pkg::OPT_HALT_DIS_BIT])
      halt_req_q <= 1'b1;
  end

  // Power state machine
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= hspsc_pkg::HSPSC_RUN;
    else
      case (state_q)
        hspsc_pkg::HSPSC_RUN:
          if (halt_req_q && tick)
            state_q <= hspsc_pkg::HSPSC_HALT;
          else if (wr_portg && reg_wdata[hspsc_pkg::PG_IDLE_BIT] && !reg_wdata[hspsc_pkg::PG_HALT_BIT])
            state_q <= hspsc_pkg::HSPSC_IDLE;
        hspsc_pkg::HSPSC_HALT:
          if (wake_event)
            state_q <= hspsc_pkg::HSPSC_WAKE;
        hspsc_pkg::HSPSC_WAKE:
          if (start_cnt_q == 9'h0)
            state_q <= hspsc_pkg::HSPSC_RUN;
        hspsc_pkg::HSPSC_IDLE:
          if (tap_toggle || wake_event)
            state_q <= hspsc_pkg::HSPSC_RUN;
        default:
          state_q <= hspsc_pkg::HSPSC_RUN;
      endcase
  end

  // Start-up count: loaded every cycle in HALT, steps only on good oscillator amplitude
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      start_cnt_q <= 9'h0;
    else if (state_q == hspsc_pkg::HSPSC_HALT)
      start_cnt_q <= hspsc_pkg::STARTUP_LOAD;
    else if (state_q == hspsc_pkg::HSPSC_WAKE && tick && fast_osc_amp_ok && start_cnt_q != 9'h0)
      start_cnt_q <= start_cnt_q - 9'h1;
  end

  // Outputs from flip-flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_clk_en <= 1'b1;
      fast_osc_run <= 1'b1;
      slow_osc_enable <= 1'b0;
      idle_clock_source_sel <= 1'b0;
      idle_irq <= 1'b0;
      self_reset_req <= 1'b0;
      fetch_restart <= 1'b1;
    end
    else
    begin
      core_clk_en <= state_q == hspsc_pkg::HSPSC_RUN;
      fast_osc_run <= state_q != hspsc_pkg::HSPSC_HALT;
      slow_osc_enable <= mode_control_reg_q[hspsc_pkg::MC_SLOW_ON_BIT];
      idle_clock_source_sel <= mode_control_reg_q[hspsc_pkg::MC_SRC_BIT];
      idle_irq <= idle_pending_flag_q && idle_int_enable_q;
      self_reset_req <= !nib_ok;
      fetch_restart <= 1'b0;
    end
  end

  // Register read port
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        hspsc_pkg::ADDR_MODE: reg_rdata <= mode_control_reg_q;
        hspsc_pkg::ADDR_ICTRL: reg_rdata <= {6'h00, idle_pending_flag_q, idle_int_enable_q};
        hspsc_pkg::ADDR_STATUS: reg_rdata <= {6'h00, state_q};
        hspsc_pkg::ADDR_OPTION: reg_rdata <= {6'h00, option_q};
        default: reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end

  // Checks
  halt_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == hspsc_pkg::HSPSC_RUN && halt_req_q && tick |=> state_q == hspsc_pkg::HSPSC_HALT)
    else $error("halt not entered");
  halt_dis_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    option_q[0] && !reg_wr |=> !halt_req_q || $past(halt_req_q))
    else $error("halt disable ignored");
  halt_osc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == hspsc_pkg::HSPSC_HALT |=> !fast_osc_run && !core_clk_en)
    else $error("clocks run in halt");
  wake_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == hspsc_pkg::HSPSC_HALT && wake_event |=> start_cnt_q == 9'h100)
    else $error("start count not loaded");
  amp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == hspsc_pkg::HSPSC_WAKE && !fast_osc_amp_ok && $past(state_q) == hspsc_pkg::HSPSC_WAKE
    |=> $stable(start_cnt_q))
    else $error("count moved on weak oscillator");
  pend_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tap_toggle |=> idle_pending_flag_q)
    else $error("pending not set");
  idle_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == hspsc_pkg::HSPSC_IDLE && tap_toggle |=> state_q == hspsc_pkg::HSPSC_RUN ##1 core_clk_en)
    else $error("idle not left");
  irq_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    idle_pending_flag_q && idle_int_enable_q |=> idle_irq)
    else $error("interrupt missing");
  bad_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !nib_ok |=> self_reset_req)
    else $error("illegal mode kept");
  idle_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == hspsc_pkg::HSPSC_IDLE |=> fast_osc_run)
    else $error("oscillator stopped in idle");
  halt_c: cover property (@(posedge ref_clk) state_q == hspsc_pkg::HSPSC_HALT ##1 state_q == hspsc_pkg::HSPSC_WAKE);
  wake_c: cover property (@(posedge ref_clk) state_q == hspsc_pkg::HSPSC_WAKE ##1 state_q == hspsc_pkg::HSPSC_RUN);
  idle_c: cover property (@(posedge ref_clk) state_q == hspsc_pkg::HSPSC_IDLE && tap_toggle);
endmodule // hspsc_ctrl

// *** hdl/hspsc_tap_sel.sv ***
// Idle window tap selector: picks one timer bit and registers its toggle
// Assumes the timer advances once per instruction tick
`timescale 1ns/10ps
module hspsc_tap_sel #(
  parameter int TW = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Timer and selection
  input wire logic [TW-1:0] timer,
  input wire logic [2:0] sel,
  // Toggle event
  output logic toggle_q
);
  logic bit_q;
  logic bit_d;
  always_comb
  begin
    // Reserved codes pick the longest window
    if (sel > hspsc_pkg::SEL_MAX)
      bit_d = timer[TW-1];
    else
      bit_d = timer[hspsc_pkg::FIRST_TAP + int'(sel)];
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      bit_q <= 1'b0;
    else
      bit_q <= bit_d;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      toggle_q <= 1'b0;
    else
      toggle_q <= bit_q != bit_d;
  end
endmodule // hspsc_tap_sel

// *** inc/hspsc_pkg.sv ***
// Package for the high-speed power-save controller
// Assumes one 20 MHz clock; instruction cycle is fast clock divided by five
package hspsc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [3:0] ADDR_PORTG = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_ICTRL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_OPTION = 4'h4;
  // Port G data register bits
  localparam int PG_HALT_BIT = 7;
  localparam int PG_IDLE_BIT = 6;
  // Mode-control register layout
  localparam int MC_SLOW_ON_BIT = 7;
  localparam int MC_FAST_ON_BIT = 6;
  localparam int MC_SRC_BIT = 5;
  localparam int MC_CORE_BIT = 4;
  localparam logic [7:0] MODE_RESET = 8'h40;
  // Legal upper nibbles of the mode-control register
  localparam logic [3:0] NIB_HIGH = 4'h4;
  localparam logic [3:0] NIB_H2D = 4'hc;
  localparam logic [3:0] NIB_DUAL = 4'he;
  localparam logic [3:0] NIB_D2L = 4'hf;
  localparam logic [3:0] NIB_LOW = 4'hb;
  // Interrupt control and option bits
  localparam int IC_ENABLE_BIT = 0;
  localparam int IC_PEND_BIT = 1;
  localparam int OPT_HALT_DIS_BIT = 0;
  localparam int OPT_CLOCK_DELAY_OPTION_BIT = 1;
  // Timing
  localparam int INSTR_DIV = 5;
  localparam logic [2:0] DIV_LAST = 3'h4;
  localparam logic [8:0] STARTUP_LOAD = 9'h100;
  localparam int TIMER_W = 16;
  localparam int FIRST_TAP = 11;
  localparam logic [2:0] SEL_MAX = 3'h4;
  typedef enum logic [1:0] {HSPSC_RUN, HSPSC_HALT, HSPSC_WAKE, HSPSC_IDLE} hspsc_state_e;
endpackage
